// File: core/ocd_pkg.sv
// Opcode encodings, lengths and cycle counts for the decode and timing block
package ocd_pkg;
    localparam logic [7:0] OP_BANK_MASK = 8'hF8;
    localparam logic [7:0] OP_PTR_MASK = 8'hFE;
    localparam logic [7:0] OP_ACC_FROM_BANK = 8'hE8;
    localparam logic [7:0] OP_ACC_FROM_DIRECT = 8'hE5;
    localparam logic [7:0] OP_ACC_FROM_PTR = 8'hE6;
    localparam logic [7:0] OP_ACC_IMMEDIATE = 8'h74;
    localparam logic [7:0] OP_BANK_FROM_ACC = 8'hF8;
    localparam logic [7:0] OP_BANK_FROM_DIRECT = 8'hA8;
    localparam logic [7:0] OP_BANK_IMMEDIATE = 8'h78;
    localparam logic [7:0] OP_DIRECT_FROM_ACC = 8'hF5;
    localparam logic [7:0] OP_DIRECT_FROM_BANK = 8'h88;
    localparam logic [7:0] OP_DIRECT_FROM_DIRECT = 8'h85;
    localparam logic [7:0] OP_DIRECT_FROM_PTR = 8'h86;
    localparam logic [7:0] OP_DIRECT_IMMEDIATE = 8'h75;
    localparam logic [7:0] OP_PTR_FROM_ACC = 8'hF6;
    localparam logic [7:0] OP_PTR_FROM_DIRECT = 8'hA6;
    localparam logic [7:0] OP_PTR_IMMEDIATE = 8'h76;
    localparam logic [7:0] OP_LOAD_DATA_POINTER = 8'h90;
    localparam logic [7:0] OP_PMEM_DATA_POINTER = 8'h93;
    localparam logic [7:0] OP_PMEM_PC = 8'h83;
    localparam logic [7:0] OP_XRAM_RD_PTR = 8'hE2;
    localparam logic [7:0] OP_XRAM_RD_DATA_POINTER = 8'hE0;
    localparam logic [7:0] OP_XRAM_WR_PTR = 8'hF2;
    localparam logic [7:0] OP_XRAM_WR_DATA_POINTER = 8'hF0;
    localparam logic [7:0] OP_PUSH = 8'hC0;
    localparam logic [7:0] OP_POP = 8'hD0;
    localparam logic [7:0] OP_TRADE_BANK = 8'hC8;
    localparam logic [7:0] OP_TRADE_DIRECT = 8'hC5;
    localparam logic [7:0] OP_TRADE_PTR = 8'hC6;
    localparam logic [7:0] OP_TRADE_NIBBLE = 8'hD6;
    localparam logic [7:0] OP_INDIRECT_BRANCH = 8'h73;
    localparam logic [7:0] OP_SHORT_BRANCH = 8'h80;
    localparam logic [7:0] OP_BR_ACC_ZERO = 8'h60;
    localparam logic [7:0] OP_BR_ACC_NONZERO = 8'h70;
    localparam logic [7:0] OP_BR_CARRY_SET = 8'h40;
    localparam logic [7:0] OP_BR_CARRY_CLEAR = 8'h50;
    localparam logic [7:0] OP_BR_BIT_SET = 8'h20;
    localparam logic [7:0] OP_BR_BIT_CLEAR = 8'h30;
    localparam logic [7:0] OP_BR_BIT_THEN_CLEAR = 8'h10;
    localparam logic [7:0] OP_CMP_ACC_DIRECT = 8'hB5;
    localparam logic [7:0] OP_CMP_ACC_IMM = 8'hB4;
    localparam logic [7:0] OP_CMP_PTR_IMM = 8'hB6;
    localparam logic [7:0] OP_CMP_BANK_IMM = 8'hB8;
    localparam logic [7:0] OP_COUNT_BANK = 8'hD8;
    localparam logic [7:0] OP_COUNT_DIRECT = 8'hD5;
    localparam logic [7:0] OP_NOP = 8'h00;
    localparam logic [7:0] OP_CLR_CARRY = 8'hC3;
    localparam logic [7:0] OP_CLR_BIT = 8'hC2;
    localparam logic [7:0] OP_SET_CARRY = 8'hD3;
    localparam logic [7:0] OP_SET_BIT = 8'hD2;
    localparam logic [7:0] OP_CPL_CARRY = 8'hB3;
    localparam logic [7:0] OP_CPL_BIT = 8'hB2;
    localparam logic [7:0] OP_AND_BIT = 8'h82;
    localparam logic [7:0] OP_AND_NBIT = 8'hB0;
    localparam logic [7:0] OP_OR_BIT = 8'h72;
    localparam logic [7:0] OP_OR_NBIT = 8'hA0;
    localparam logic [7:0] OP_BIT_TO_CARRY = 8'hA2;
    localparam logic [7:0] OP_CARRY_TO_BIT = 8'h92;

    localparam logic [1:0] LEN_1 = 2'h1;
    localparam logic [1:0] LEN_2 = 2'h2;
    localparam logic [1:0] LEN_3 = 2'h3;
    localparam logic [3:0] CYC_1 = 4'h1;
    localparam logic [3:0] CYC_2 = 4'h2;
    localparam logic [3:0] CYC_3 = 4'h3;
    localparam logic [3:0] CYC_4 = 4'h4;
    localparam logic [3:0] CYC_5 = 4'h5;
    localparam logic [3:0] CYC_6 = 4'h6;
    localparam logic [3:0] CYC_7 = 4'h7;
    localparam logic [3:0] CYC_8 = 4'h8;

    typedef enum logic [4:0] {
        OCD_CLS_NONE, OCD_CLS_COPY, OCD_CLS_PMEM_READ, OCD_CLS_XRAM_READ, OCD_CLS_XRAM_WRITE,
        OCD_CLS_PUSH, OCD_CLS_POP, OCD_CLS_TRADE, OCD_CLS_TRADE_NIBBLE, OCD_CLS_INDIRECT_BRANCH,
        OCD_CLS_SHORT_BRANCH, OCD_CLS_COND_BRANCH, OCD_CLS_COMPARE_BRANCH, OCD_CLS_COUNT_BRANCH,
        OCD_CLS_CARRY_LOGIC, OCD_CLS_BIT_MOVE, OCD_CLS_BIT_SET_CLR, OCD_CLS_UNKNOWN
    } ocd_class_e;

    typedef enum logic [3:0] {
        OCD_SRC_NONE, OCD_SRC_ACC, OCD_SRC_BANK, OCD_SRC_DIRECT, OCD_SRC_PTR_RAM, OCD_SRC_IMM,
        OCD_SRC_IMM16, OCD_SRC_PMEM_DATA_POINTER, OCD_SRC_PMEM_PC, OCD_SRC_XRAM_PTR, OCD_SRC_XRAM_DATA_POINTER,
        OCD_SRC_STACK, OCD_SRC_BIT, OCD_SRC_NBIT, OCD_SRC_CARRY
    } ocd_src_e;

    typedef enum logic [3:0] {
        OCD_DST_NONE, OCD_DST_ACC, OCD_DST_BANK, OCD_DST_DIRECT, OCD_DST_PTR_RAM, OCD_DST_DATA_POINTER,
        OCD_DST_XRAM_PTR, OCD_DST_XRAM_DATA_POINTER, OCD_DST_STACK, OCD_DST_PC, OCD_DST_CARRY, OCD_DST_BIT
    } ocd_dst_e;

    typedef enum logic [3:0] {
        OCD_CND_ALWAYS, OCD_CND_ACC_ZERO, OCD_CND_ACC_NONZERO, OCD_CND_CARRY_SET,
        OCD_CND_CARRY_CLEAR, OCD_CND_BIT_SET, OCD_CND_BIT_CLEAR, OCD_CND_UNEQUAL, OCD_CND_COUNT_NONZERO
    } ocd_cond_e;

    typedef enum logic [1:0] {OCD_LOGIC_NONE, OCD_LOGIC_AND, OCD_LOGIC_OR} ocd_logic_e;
endpackage : ocd_pkg

// File: core/ocd_decode.sv
// Opcode decoder with per-instruction machine cycle sequencing
`timescale 1ns/1ps
module ocd_decode
    import ocd_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Fetch side
    input wire logic opcode_valid,
    input wire logic [7:0] opcode,
    output logic opcode_ready,
    // Branch condition from the execute stage
    input wire logic branch_taken,
    // Decoded instruction, held for the whole execution; busy, instr_cycles, cycle_index and instr_done are live
    output logic busy,
    output logic [1:0] instr_bytes,
    output logic [3:0] instr_cycles,
    output logic [2:0] reg_index,
    output logic ptr_index,
    output logic clear_tested_bit,
    output logic branch_op,
    output ocd_class_e op_class,
    output ocd_src_e op_src,
    output ocd_dst_e op_dst,
    output ocd_cond_e op_cond,
    output ocd_logic_e op_logic,
    output logic [3:0] cycle_index,
    output logic instr_done
);
    typedef enum logic {OCD_IDLE, OCD_EXEC} ocd_state_e;

    ocd_state_e state_q;
    // Decode of the offered opcode
    logic [1:0] len_d;
    logic [3:0] cyc_nt_d;
    logic [3:0] cyc_t_d;
    logic cond_d;
    ocd_class_e cls_d;
    ocd_src_e src_d;
    ocd_dst_e dst_d;
    ocd_cond_e cnd_d;
    ocd_logic_e lgc_d;
    logic clr_d;
    // Timing held for the instruction in flight
    logic [3:0] cyc_nt_q;
    logic [3:0] cyc_t_q;
    logic cond_q;
    logic [3:0] count_q;
    logic [3:0] target;

    // Masked groups first; register and pointer forms share one pattern
    always_comb begin
        len_d = LEN_1;
        cyc_nt_d = CYC_1;
        cond_d = 1'b0;
        cls_d = OCD_CLS_COPY;
        src_d = OCD_SRC_NONE;
        dst_d = OCD_DST_NONE;
        cnd_d = OCD_CND_ALWAYS;
        lgc_d = OCD_LOGIC_NONE;
        clr_d = 1'b0;
        if ((opcode & OP_BANK_MASK) == OP_ACC_FROM_BANK) begin
            src_d = OCD_SRC_BANK; dst_d = OCD_DST_ACC;
        end else if ((opcode & OP_BANK_MASK) == OP_BANK_FROM_ACC) begin
            src_d = OCD_SRC_ACC; dst_d = OCD_DST_BANK; cyc_nt_d = CYC_2;
        end else if ((opcode & OP_BANK_MASK) == OP_BANK_FROM_DIRECT) begin
            src_d = OCD_SRC_DIRECT; dst_d = OCD_DST_BANK; len_d = LEN_2; cyc_nt_d = CYC_3;
        end else if ((opcode & OP_BANK_MASK) == OP_BANK_IMMEDIATE) begin
            src_d = OCD_SRC_IMM; dst_d = OCD_DST_BANK; len_d = LEN_2; cyc_nt_d = CYC_2;
        end else if ((opcode & OP_BANK_MASK) == OP_DIRECT_FROM_BANK) begin
            src_d = OCD_SRC_BANK; dst_d = OCD_DST_DIRECT; len_d = LEN_2; cyc_nt_d = CYC_2;
        end else if ((opcode & OP_BANK_MASK) == OP_TRADE_BANK) begin
            cls_d = OCD_CLS_TRADE; src_d = OCD_SRC_BANK; dst_d = OCD_DST_ACC; cyc_nt_d = CYC_3;
        end else if ((opcode & OP_BANK_MASK) == OP_CMP_BANK_IMM) begin
            cls_d = OCD_CLS_COMPARE_BRANCH; src_d = OCD_SRC_BANK; cnd_d = OCD_CND_UNEQUAL;
            len_d = LEN_3; cyc_nt_d = CYC_4; cond_d = 1'b1;
        end else if ((opcode & OP_BANK_MASK) == OP_COUNT_BANK) begin
            cls_d = OCD_CLS_COUNT_BRANCH; src_d = OCD_SRC_BANK; cnd_d = OCD_CND_COUNT_NONZERO;
            len_d = LEN_2; cyc_nt_d = CYC_3; cond_d = 1'b1;
        end else if ((opcode & OP_PTR_MASK) == OP_ACC_FROM_PTR) begin
            src_d = OCD_SRC_PTR_RAM; dst_d = OCD_DST_ACC; cyc_nt_d = CYC_2;
        end else if ((opcode & OP_PTR_MASK) == OP_DIRECT_FROM_PTR) begin
            src_d = OCD_SRC_PTR_RAM; dst_d = OCD_DST_DIRECT; len_d = LEN_2; cyc_nt_d = CYC_3;
        end else if ((opcode & OP_PTR_MASK) == OP_PTR_FROM_ACC) begin
            src_d = OCD_SRC_ACC; dst_d = OCD_DST_PTR_RAM; cyc_nt_d = CYC_2;
        end else if ((opcode & OP_PTR_MASK) == OP_PTR_FROM_DIRECT) begin
            src_d = OCD_SRC_DIRECT; dst_d = OCD_DST_PTR_RAM; len_d = LEN_2; cyc_nt_d = CYC_3;
        end else if ((opcode & OP_PTR_MASK) == OP_PTR_IMMEDIATE) begin
            src_d = OCD_SRC_IMM; dst_d = OCD_DST_PTR_RAM; len_d = LEN_2; cyc_nt_d = CYC_2;
        end else if ((opcode & OP_PTR_MASK) == OP_XRAM_RD_PTR) begin
            cls_d = OCD_CLS_XRAM_READ; src_d = OCD_SRC_XRAM_PTR; dst_d = OCD_DST_ACC; cyc_nt_d = CYC_5;
        end else if ((opcode & OP_PTR_MASK) == OP_XRAM_WR_PTR) begin
            cls_d = OCD_CLS_XRAM_WRITE; src_d = OCD_SRC_ACC; dst_d = OCD_DST_XRAM_PTR; cyc_nt_d = CYC_4;
        end else if ((opcode & OP_PTR_MASK) == OP_TRADE_PTR) begin
            cls_d = OCD_CLS_TRADE; src_d = OCD_SRC_PTR_RAM; dst_d = OCD_DST_ACC; cyc_nt_d = CYC_4;
        end else if ((opcode & OP_PTR_MASK) == OP_TRADE_NIBBLE) begin
            cls_d = OCD_CLS_TRADE_NIBBLE; src_d = OCD_SRC_PTR_RAM; dst_d = OCD_DST_ACC; cyc_nt_d = CYC_4;
        end else if ((opcode & OP_PTR_MASK) == OP_CMP_PTR_IMM) begin
            cls_d = OCD_CLS_COMPARE_BRANCH; src_d = OCD_SRC_PTR_RAM; cnd_d = OCD_CND_UNEQUAL;
            len_d = LEN_3; cyc_nt_d = CYC_4; cond_d = 1'b1;
        end else begin
            // Remaining forms need the whole byte to match
            case (opcode)
                OP_ACC_FROM_DIRECT: begin
                    src_d = OCD_SRC_DIRECT; dst_d = OCD_DST_ACC; len_d = LEN_2; cyc_nt_d = CYC_2;
                end
                OP_ACC_IMMEDIATE: begin
                    src_d = OCD_SRC_IMM; dst_d = OCD_DST_ACC; len_d = LEN_2; cyc_nt_d = CYC_2;
                end
                OP_DIRECT_FROM_ACC: begin
                    src_d = OCD_SRC_ACC; dst_d = OCD_DST_DIRECT; len_d = LEN_2; cyc_nt_d = CYC_2;
                end
                OP_DIRECT_FROM_DIRECT: begin
                    src_d = OCD_SRC_DIRECT; dst_d = OCD_DST_DIRECT; len_d = LEN_3; cyc_nt_d = CYC_3;
                end
                OP_DIRECT_IMMEDIATE: begin
                    src_d = OCD_SRC_IMM; dst_d = OCD_DST_DIRECT; len_d = LEN_3; cyc_nt_d = CYC_3;
                end
                OP_LOAD_DATA_POINTER: begin
                    src_d = OCD_SRC_IMM16; dst_d = OCD_DST_DATA_POINTER; len_d = LEN_3; cyc_nt_d = CYC_3;
                end
                OP_PMEM_DATA_POINTER: begin
                    cls_d = OCD_CLS_PMEM_READ; src_d = OCD_SRC_PMEM_DATA_POINTER; dst_d = OCD_DST_ACC;
                    cyc_nt_d = CYC_7;
                end
                OP_PMEM_PC: begin
                    cls_d = OCD_CLS_PMEM_READ; src_d = OCD_SRC_PMEM_PC; dst_d = OCD_DST_ACC;
                    cyc_nt_d = CYC_8;
                end
                OP_XRAM_RD_DATA_POINTER: begin
                    cls_d = OCD_CLS_XRAM_READ; src_d = OCD_SRC_XRAM_DATA_POINTER; dst_d = OCD_DST_ACC;
                    cyc_nt_d = CYC_6;
                end
                OP_XRAM_WR_DATA_POINTER: begin
                    cls_d = OCD_CLS_XRAM_WRITE; src_d = OCD_SRC_ACC; dst_d = OCD_DST_XRAM_DATA_POINTER;
                    cyc_nt_d = CYC_5;
                end
                OP_PUSH: begin
                    cls_d = OCD_CLS_PUSH; src_d = OCD_SRC_DIRECT; dst_d = OCD_DST_STACK;
                    len_d = LEN_2; cyc_nt_d = CYC_5;
                end
                OP_POP: begin
                    cls_d = OCD_CLS_POP; src_d = OCD_SRC_STACK; dst_d = OCD_DST_DIRECT;
                    len_d = LEN_2; cyc_nt_d = CYC_4;
                end
                OP_TRADE_DIRECT: begin
                    cls_d = OCD_CLS_TRADE; src_d = OCD_SRC_DIRECT; dst_d = OCD_DST_ACC;
                    len_d = LEN_2; cyc_nt_d = CYC_4;
                end
                OP_INDIRECT_BRANCH: begin
                    cls_d = OCD_CLS_INDIRECT_BRANCH; dst_d = OCD_DST_PC; cyc_nt_d = CYC_6;
                end
                OP_SHORT_BRANCH: begin
                    cls_d = OCD_CLS_SHORT_BRANCH; dst_d = OCD_DST_PC; len_d = LEN_2; cyc_nt_d = CYC_4;
                end
                OP_BR_ACC_ZERO, OP_BR_ACC_NONZERO: begin
                    cls_d = OCD_CLS_COND_BRANCH; src_d = OCD_SRC_ACC; len_d = LEN_2;
                    cyc_nt_d = CYC_3; cond_d = 1'b1;
                    cnd_d = (opcode == OP_BR_ACC_ZERO) ? OCD_CND_ACC_ZERO : OCD_CND_ACC_NONZERO;
                end
                OP_BR_CARRY_SET, OP_BR_CARRY_CLEAR: begin
                    cls_d = OCD_CLS_COND_BRANCH; src_d = OCD_SRC_CARRY; len_d = LEN_2;
                    cyc_nt_d = CYC_2; cond_d = 1'b1;
                    cnd_d = (opcode == OP_BR_CARRY_SET) ? OCD_CND_CARRY_SET : OCD_CND_CARRY_CLEAR;
                end
                OP_BR_BIT_SET, OP_BR_BIT_CLEAR, OP_BR_BIT_THEN_CLEAR: begin
                    cls_d = OCD_CLS_COND_BRANCH; src_d = OCD_SRC_BIT; len_d = LEN_3;
                    cyc_nt_d = CYC_4; cond_d = 1'b1;
                    cnd_d = (opcode == OP_BR_BIT_CLEAR) ? OCD_CND_BIT_CLEAR : OCD_CND_BIT_SET;
                    clr_d = (opcode == OP_BR_BIT_THEN_CLEAR);
                end
                OP_CMP_ACC_DIRECT, OP_CMP_ACC_IMM: begin
                    cls_d = OCD_CLS_COMPARE_BRANCH; src_d = OCD_SRC_ACC; cnd_d = OCD_CND_UNEQUAL;
                    len_d = LEN_3; cyc_nt_d = CYC_4; cond_d = 1'b1;
                end
                OP_COUNT_DIRECT: begin
                    cls_d = OCD_CLS_COUNT_BRANCH; src_d = OCD_SRC_DIRECT; cnd_d = OCD_CND_COUNT_NONZERO;
                    len_d = LEN_3; cyc_nt_d = CYC_4; cond_d = 1'b1;
                end
                OP_AND_BIT, OP_AND_NBIT, OP_OR_BIT, OP_OR_NBIT: begin
                    cls_d = OCD_CLS_CARRY_LOGIC; dst_d = OCD_DST_CARRY; len_d = LEN_2; cyc_nt_d = CYC_2;
                    src_d = (opcode == OP_AND_NBIT || opcode == OP_OR_NBIT) ? OCD_SRC_NBIT : OCD_SRC_BIT;
                    lgc_d = (opcode == OP_AND_BIT || opcode == OP_AND_NBIT) ? OCD_LOGIC_AND : OCD_LOGIC_OR;
                end
                OP_BIT_TO_CARRY: begin
                    cls_d = OCD_CLS_BIT_MOVE; src_d = OCD_SRC_BIT; dst_d = OCD_DST_CARRY;
                    len_d = LEN_2; cyc_nt_d = CYC_2;
                end
                OP_CARRY_TO_BIT: begin
                    cls_d = OCD_CLS_BIT_MOVE; src_d = OCD_SRC_CARRY; dst_d = OCD_DST_BIT;
                    len_d = LEN_2; cyc_nt_d = CYC_3;
                end
                OP_CLR_CARRY, OP_SET_CARRY, OP_CPL_CARRY: begin
                    cls_d = OCD_CLS_BIT_SET_CLR; dst_d = OCD_DST_CARRY;
                end
                OP_CLR_BIT, OP_SET_BIT, OP_CPL_BIT: begin
                    cls_d = OCD_CLS_BIT_SET_CLR; dst_d = OCD_DST_BIT; len_d = LEN_2; cyc_nt_d = CYC_3;
                end
                OP_NOP: cls_d = OCD_CLS_NONE;
                // Groups decoded elsewhere still take one byte, one cycle here
                default: cls_d = OCD_CLS_UNKNOWN;
            endcase
        end
    end

    // Taken conditional branches always cost two extra cycles
    assign cyc_t_d = cond_d ? 4'(cyc_nt_d + CYC_2) : cyc_nt_d;
    assign opcode_ready = (state_q == OCD_IDLE);
    assign busy = (state_q == OCD_EXEC);
    // Condition read live; execute must hold it until instr_done, as a taken branch ends on the long count
    assign target = (cond_q && branch_taken) ? cyc_t_q : cyc_nt_q;
    assign instr_cycles = target;
    assign cycle_index = count_q;
    assign instr_done = busy && (count_q == target);

    // Back-to-back loads keep the machine in execute
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_q <= OCD_IDLE;
        end else begin
            case (state_q)
                OCD_IDLE: if (opcode_valid) state_q <= OCD_EXEC;
                OCD_EXEC: if (instr_done && !opcode_valid) state_q <= OCD_IDLE;
                default: state_q <= OCD_IDLE;
            endcase
        end
    end

    // Cycle counter runs from 1 up to the full count
    always_ff @(posedge core_clk) begin
        if (srst) begin
            count_q <= CYC_1;
        end else if (instr_done || !busy) begin
            count_q <= CYC_1;
        end else begin
            // Restarted at the end, so never passes the longest count
            count_q <= 4'(count_q + CYC_1);
        end
    end

    // Back-to-back load happens on the finishing cycle, no bubble
    always_ff @(posedge core_clk) begin
        if (srst) begin
            instr_bytes <= LEN_1;
            cyc_nt_q <= CYC_1;
            cyc_t_q <= CYC_1;
            cond_q <= 1'b0;
            reg_index <= 3'h0;
            ptr_index <= 1'b0;
            clear_tested_bit <= 1'b0;
            branch_op <= 1'b0;
            op_class <= OCD_CLS_NONE;
            op_src <= OCD_SRC_NONE;
            op_dst <= OCD_DST_NONE;
            op_cond <= OCD_CND_ALWAYS;
            op_logic <= OCD_LOGIC_NONE;
        end else if (opcode_valid && (!busy || instr_done)) begin
            instr_bytes <= len_d;
            cyc_nt_q <= cyc_nt_d;
            cyc_t_q <= cyc_t_d;
            cond_q <= cond_d;
            // Register and pointer selects ride in the low opcode bits
            reg_index <= opcode[2:0];
            ptr_index <= opcode[0];
            clear_tested_bit <= clr_d;
            branch_op <= cond_d || dst_d == OCD_DST_PC;
            op_class <= cls_d;
            op_src <= src_d;
            op_dst <= dst_d;
            op_cond <= cnd_d;
            op_logic <= lgc_d;
        end
    end
endmodule : ocd_decode

// File: verification/ocd_decode_asserts.sv
// Timing checks on the opcode decoder ports
`timescale 1ns/1ps
module ocd_decode_asserts
    import ocd_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Fetch side and condition
    input wire logic opcode_valid,
    input wire logic [7:0] opcode,
    input wire logic opcode_ready,
    input wire logic branch_taken,
    // Decode outputs
    input wire logic busy,
    input wire logic [1:0] instr_bytes,
    input wire logic [3:0] instr_cycles,
    input wire logic [2:0] reg_index,
    input wire logic [3:0] cycle_index,
    input wire logic instr_done
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    sequence s_take(logic [7:0] op);
        opcode_valid && (!busy || instr_done) && opcode == op;
    endsequence

    AST_READY_IDLE: assert property (opcode_ready == !busy)
        else $error("ready does not mirror idle");
    AST_TAKE: assert property (opcode_valid && (!busy || instr_done) |=> busy && cycle_index == CYC_1)
        else $error("opcode not taken");
    AST_DONE: assert property (instr_done == (busy && cycle_index == instr_cycles))
        else $error("done pulse misplaced");
    AST_STEP: assert property (busy && !instr_done |=> busy && cycle_index == $past(cycle_index) + 4'h1)
        else $error("cycle count did not advance");
    AST_END: assert property (instr_done && !opcode_valid |=> !busy)
        else $error("busy held past the last cycle");
    AST_HOLD: assert property (busy && !instr_done |=> $stable(instr_bytes) && $stable(reg_index))
        else $error("decoded fields changed mid instruction");
    AST_BANK_TO_ACC: assert property (opcode_valid && !busy && (opcode & OP_BANK_MASK) == OP_ACC_FROM_BANK
        |=> instr_cycles == CYC_1 && {5'h00, reg_index} == ($past(opcode) & 8'h07))
        else $error("bank copy decode wrong");
    AST_PMEM_PC: assert property (s_take(OP_PMEM_PC) |=> instr_cycles == CYC_8 ##7 instr_done)
        else $error("code read via program counter not eight cycles");
    AST_CARRY_NOT_TAKEN: assert property (s_take(OP_BR_CARRY_SET) ##1 !branch_taken [*2] |-> instr_done)
        else $error("untaken carry branch not two cycles");
endmodule : ocd_decode_asserts

bind ocd_decode ocd_decode_asserts u_asserts (.core_clk(core_clk), .srst(srst), .opcode_valid(opcode_valid),
    .opcode(opcode), .opcode_ready(opcode_ready), .branch_taken(branch_taken), .busy(busy),
    .instr_bytes(instr_bytes), .instr_cycles(instr_cycles), .reg_index(reg_index),
    .cycle_index(cycle_index), .instr_done(instr_done));

// File: verification/ocd_decode_tb_top.sv
// Self-checking bench for the opcode decoder
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("[ERR] %s expected %0h seen %0h", nm, ex, got); end end
module ocd_decode_tb_top import ocd_pkg::*;;
    logic core_clk, srst, opcode_valid, branch_taken;
    logic [7:0] opcode;
    logic opcode_ready, busy, clear_tested_bit, instr_done;
    logic [1:0] instr_bytes;
    logic [3:0] instr_cycles, cycle_index;
    logic [2:0] reg_index;
    logic ptr_index, branch_op;
    ocd_class_e op_class;
    ocd_src_e op_src;
    ocd_dst_e op_dst;
    ocd_cond_e op_cond;
    ocd_logic_e op_logic;
    int n_mismatch = 0, cmp_count = 0, cyc = 0, n;
    // Rows: opcode, branch_taken, bytes, cycles
    logic [19:0] rows [71] = '{
        20'hE8011, 20'hEF011, 20'hE5022, 20'h74022, 20'hF8012, 20'hFF012,
        20'hA8023, 20'h85033, 20'h86023, 20'h87023, 20'hF6012, 20'hF7012, 20'h90033,
        20'h93017, 20'h83018, 20'hE2015, 20'hE3015, 20'hE0016, 20'hF2014, 20'hF3014, 20'hF0015,
        20'hC0025, 20'hD0024, 20'hD6014, 20'hD7014, 20'hC8013, 20'hCF013, 20'h73016, 20'h80024,
        20'h60023, 20'h60125, 20'h70023, 20'h70125, 20'h40022, 20'h40124, 20'h50022, 20'h50124,
        20'h10034, 20'h10136, 20'h20034, 20'h20136, 20'h30034, 20'h30136,
        20'hB4034, 20'hB5136, 20'hB6034, 20'hB7136, 20'hB8034, 20'hBF136,
        20'hD8023, 20'hDF125, 20'hD5034, 20'hD5136,
        20'h82022, 20'hB0022, 20'h72022, 20'hA0022, 20'hA2022, 20'h92023,
        20'hE6012, 20'h78022, 20'hF5022, 20'h88022, 20'h75033, 20'hA6023,
        20'h76022, 20'hC5024, 20'hC6014, 20'hC3011, 20'hC2023, 20'h00011
    };

    ocd_decode uut (.core_clk(core_clk), .srst(srst), .opcode_valid(opcode_valid), .opcode(opcode),
        .opcode_ready(opcode_ready), .branch_taken(branch_taken), .busy(busy), .instr_bytes(instr_bytes),
        .instr_cycles(instr_cycles), .reg_index(reg_index), .ptr_index(ptr_index),
        .clear_tested_bit(clear_tested_bit), .branch_op(branch_op), .op_class(op_class), .op_src(op_src),
        .op_dst(op_dst), .op_cond(op_cond), .op_logic(op_logic), .cycle_index(cycle_index),
        .instr_done(instr_done));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // Whole run needs well under a thousand cycles
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_mismatch++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test

    // Condition that each branch opcode tests
    function automatic ocd_cond_e exp_cond(input logic [7:0] op);
        if (op == 8'h60) return OCD_CND_ACC_ZERO;
        if (op == 8'h70) return OCD_CND_ACC_NONZERO;
        if (op == 8'h40) return OCD_CND_CARRY_SET;
        if (op == 8'h50) return OCD_CND_CARRY_CLEAR;
        if (op == 8'h30) return OCD_CND_BIT_CLEAR;
        if (op inside {8'h10, 8'h20}) return OCD_CND_BIT_SET;
        if (op inside {[8'hB4:8'hBF]}) return OCD_CND_UNEQUAL;
        if (op inside {8'hD5, [8'hD8:8'hDF]}) return OCD_CND_COUNT_NONZERO;
        return OCD_CND_ALWAYS;
    endfunction : exp_cond

    function automatic ocd_logic_e exp_logic(input logic [7:0] op);
        if (op inside {8'h82, 8'hB0}) return OCD_LOGIC_AND;
        if (op inside {8'h72, 8'hA0}) return OCD_LOGIC_OR;
        return OCD_LOGIC_NONE;
    endfunction : exp_logic

    // Entered on a rising edge with the decoder idle
    task automatic run_op(input logic [19:0] r);
        int k;
        logic [7:0] op;
        op = r[19:12];
        opcode_valid <= 1'b1;
        opcode <= r[19:12];
        branch_taken <= r[8];
        @(posedge core_clk);
        opcode_valid <= 1'b0;
        k = 1;
        #1;
        while (instr_done !== 1'b1 && k < 12) begin
            @(posedge core_clk);
            #1;
            k++;
        end
        `CHK("cycles", r[3:0], k[3:0])
        `CHK("instr_cycles", r[3:0], instr_cycles)
        `CHK("instr_bytes", r[5:4], instr_bytes)
        `CHK("reg_index", r[14:12], reg_index)
        `CHK("clear_bit", r[19:12] == OP_BR_BIT_THEN_CLEAR, clear_tested_bit)
        `CHK("ptr_index", r[12], ptr_index)
        `CHK("branch_op", exp_cond(op) != OCD_CND_ALWAYS || op inside {8'h73, 8'h80}, branch_op)
        `CHK("op_cond", exp_cond(op), op_cond)
        `CHK("to_pc", op inside {8'h73, 8'h80}, op_dst == OCD_DST_PC)
        `CHK("nbit", op inside {8'hB0, 8'hA0}, op_src == OCD_SRC_NBIT)
        `CHK("nibble", op inside {8'hD6, 8'hD7}, op_class == OCD_CLS_TRADE_NIBBLE)
        `CHK("op_logic", exp_logic(op), op_logic)
        @(posedge core_clk);
    endtask : run_op

    initial begin
        srst = 1'b1;
        opcode_valid = 1'b0;
        opcode = 8'h00;
        branch_taken = 1'b0;
        repeat (12) @(posedge core_clk);
        srst <= 1'b0;
        #1;
        `CHK("rst_busy", 1'b0, busy)
        `CHK("rst_ready", 1'b1, opcode_ready)
        `CHK("rst_index", 4'h1, cycle_index)
        `CHK("rst_done", 1'b0, instr_done)
        @(posedge core_clk);
        foreach (rows[i]) run_op(rows[i]);
        // Held request reloads only on the last cycle
        opcode_valid <= 1'b1;
        opcode <= OP_ACC_FROM_DIRECT;
        @(posedge core_clk);
        #1;
        n = 0;
        repeat (6) begin
            `CHK("b2b_busy", 1'b1, busy)
            n += instr_done;
            @(posedge core_clk);
            #1;
        end
        `CHK("b2b_done", 3, n)
        @(posedge core_clk);
        opcode_valid <= 1'b0;
        @(posedge core_clk);
        // Reset in mid instruction
        opcode_valid <= 1'b1;
        opcode <= OP_PMEM_PC;
        repeat (4) @(posedge core_clk);
        srst <= 1'b1;
        opcode_valid <= 1'b0;
        @(posedge core_clk);
        srst <= 1'b0;
        #1;
        `CHK("mid_busy", 1'b0, busy)
        `CHK("mid_index", 4'h1, cycle_index)
        `CHK("mid_class", OCD_CLS_NONE, op_class)
        `CHK("mid_bytes", 2'h1, instr_bytes)
        @(posedge core_clk);
        run_op(20'h74022);
        stop_test();
    end
endmodule : ocd_decode_tb_top
